// ==== pomrps_top.sv ====
`timescale 1ns/10ps
module pomrps_top
  import pomrps_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_wr_bit,
  input wire logic [2:0] i_bit_pos,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [P0_PINS-1:0] i_p0_in,
  output logic [P0_PINS-1:0] o_p0_out,
  output logic [P0_PINS-1:0] o_p0_oe,
  input wire logic [P2_PINS-1:0] i_p2_in,
  output logic [P2_PINS-1:0] o_p2_out,
  output logic [P2_PINS-1:0] o_p2_oe,
  input wire logic [P3_PINS-1:0] i_p3_in,
  output logic [P3_PINS-1:0] o_p3_out,
  output logic [P3_PINS-1:0] o_p3_oe,
  input wire logic [P6_PINS-1:0] i_p6_in,
  output logic [P6_PINS-1:0] o_p6_out,
  output logic [P6_PINS-1:0] o_p6_oe,
  input wire logic [1:0] i_p12_in,
  input wire logic i_rst_pin_n,
  output logic o_ext_reset_req
);

  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] port0_data;
  logic [7:0] port2_data;
  logic [7:0] port3_data;
  logic [7:0] port6_data;
  logic [7:0] port0_direction;
  logic [7:0] port2_direction;
  logic [7:0] port3_direction;
  logic [7:0] port6_output_driver_mode;
  logic [7:0] reset_pin_function_select;
  logic [7:0] port6_direction;
  pomrps_sel_t sel;
  logic [7:0] next_rdata;
  logic [7:0] port12_input;
  logic [1:0] p12_meta;
  logic [1:0] p12_sync;
  logic input_only_port_bit;
  logic reset_pin_select_bit;

  pomrps_pin_if #(.N(P0_PINS)) p0_if();
  pomrps_pin_if #(.N(P2_PINS)) p2_if();
  pomrps_pin_if #(.N(P3_PINS)) p3_if();
  pomrps_pin_if #(.N(P6_PINS)) p6_if();

  // Merges a byte or single-bit write, keeps unused bits at their fill.
  function automatic logic [7:0] merge_write(
    input logic [7:0] cur,
    input logic [7:0] msk,
    input logic [7:0] fill,
    input logic byte_en,
    input logic bit_en,
    input logic [2:0] pos,
    input logic [7:0] d
  );
    logic [7:0] v;
    v = cur;
    if (byte_en) begin
      v = d;
    end else if (bit_en) begin
      v[pos] = d[0];
    end
    return (v & msk) | (fill & ~msk);
  endfunction

  // Input pins read their level, output pins read the latch.
  function automatic logic [7:0] port_read(
    input logic [7:0] latch,
    input logic [7:0] dir,
    input logic [7:0] level,
    input logic [7:0] msk
  );
    return ((latch & ~dir) | (level & dir)) & msk;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    unique case (i_addr)
      ADDR_P0_DATA: sel = SEL_P0;
      ADDR_P2_DATA: sel = SEL_P2;
      ADDR_P3_DATA: sel = SEL_P3;
      ADDR_P6_DATA: sel = SEL_P6;
      ADDR_P12_INPUT: sel = SEL_P12;
      ADDR_P0_DIR: sel = SEL_DIR0;
      ADDR_P2_DIR: sel = SEL_DIR2;
      ADDR_P3_DIR: sel = SEL_DIR3;
      ADDR_P6_MODE: sel = SEL_MODE6;
      ADDR_RST_SEL: sel = SEL_RSTSEL;
      default: sel = SEL_NONE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      port0_data <= DATA_RST;
      port2_data <= DATA_RST;
      port3_data <= DATA_RST;
      port6_data <= DATA_RST;
    end else begin
      if (sel == SEL_P0) begin
        port0_data <= merge_write(port0_data, P0_MASK, FILL_ZERO,
                                  i_wr, i_wr_bit, i_bit_pos, i_wdata);
      end
      if (sel == SEL_P2) begin
        port2_data <= merge_write(port2_data, P2_MASK, FILL_ZERO,
                                  i_wr, i_wr_bit, i_bit_pos, i_wdata);
      end
      if (sel == SEL_P3) begin
        port3_data <= merge_write(port3_data, P3_MASK, FILL_ZERO,
                                  i_wr, i_wr_bit, i_bit_pos, i_wdata);
      end
      if (sel == SEL_P6) begin
        port6_data <= merge_write(port6_data, P6_MASK, FILL_ZERO,
                                  i_wr, i_wr_bit, i_bit_pos, i_wdata);
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      port0_direction <= DIR_RST;
      port2_direction <= DIR_RST;
      port3_direction <= DIR_RST;
    end else begin
      if (sel == SEL_DIR0) begin
        port0_direction <= merge_write(port0_direction, P0_MASK, FILL_ONE,
                                       i_wr, i_wr_bit, i_bit_pos, i_wdata);
      end
      if (sel == SEL_DIR2) begin
        port2_direction <= merge_write(port2_direction, P2_MASK, FILL_ONE,
                                       i_wr, i_wr_bit, i_bit_pos, i_wdata);
      end
      if (sel == SEL_DIR3) begin
        port3_direction <= merge_write(port3_direction, P3_MASK, FILL_ONE,
                                       i_wr, i_wr_bit, i_bit_pos, i_wdata);
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      port6_output_driver_mode <= MODE6_RST;
    end else if (sel == SEL_MODE6) begin
      port6_output_driver_mode <= merge_write(port6_output_driver_mode,
                                              MODE6_MASK, FILL_ZERO, i_wr,
                                              i_wr_bit, i_bit_pos, i_wdata);
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      reset_pin_function_select <= RST_SEL_RST;
    end else if (sel == SEL_RSTSEL) begin
      reset_pin_function_select <= merge_write(reset_pin_function_select,
                                               RST_SEL_MASK, FILL_ZERO, i_wr,
                                               i_wr_bit, i_bit_pos, i_wdata);
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Port 6 has no direction register here, so its pins are always outputs.
  assign port6_direction = FILL_ZERO;

  assign p0_if.value = port0_data[P0_PINS-1:0];
  assign p0_if.dir_in = port0_direction[P0_PINS-1:0];
  assign p0_if.open_drain = '0;
  assign p2_if.value = port2_data[P2_PINS-1:0];
  assign p2_if.dir_in = port2_direction[P2_PINS-1:0];
  assign p2_if.open_drain = '0;
  assign p3_if.value = port3_data[P3_PINS-1:0];
  assign p3_if.dir_in = port3_direction[P3_PINS-1:0];
  assign p3_if.open_drain = '0;
  assign p6_if.value = port6_data[P6_PINS-1:0];
  assign p6_if.dir_in = port6_direction[P6_PINS-1:0];
  assign p6_if.open_drain = port6_output_driver_mode[P6_PINS-1:0];

  pomrps_pin_drv #(.N(P0_PINS)) u_p0 (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_pad_in(i_p0_in),
    .pins(p0_if.drv)
  );

  pomrps_pin_drv #(.N(P2_PINS)) u_p2 (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_pad_in(i_p2_in),
    .pins(p2_if.drv)
  );

  pomrps_pin_drv #(.N(P3_PINS)) u_p3 (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_pad_in(i_p3_in),
    .pins(p3_if.drv)
  );

  pomrps_pin_drv #(.N(P6_PINS)) u_p6 (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_pad_in(i_p6_in),
    .pins(p6_if.drv)
  );

  assign o_p0_out = p0_if.pad_out;
  assign o_p0_oe = p0_if.pad_oe;
  assign o_p2_out = p2_if.pad_out;
  assign o_p2_oe = p2_if.pad_oe;
  assign o_p3_out = p3_if.pad_out;
  assign o_p3_oe = p3_if.pad_oe;
  assign o_p6_out = p6_if.pad_out;
  assign o_p6_oe = p6_if.pad_oe;

  ////////////////////////////////////////////////////////////////////////////

  assign reset_pin_select_bit = reset_pin_function_select[RST_SEL_BIT];

  pomrps_rst_sel u_rst_sel (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_pin_n(i_rst_pin_n),
    .i_port_mode(reset_pin_select_bit),
    .o_level(input_only_port_bit),
    .o_reset_req(o_ext_reset_req)
  );

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      p12_meta <= '0;
      p12_sync <= '0;
    end else begin
      p12_meta <= i_p12_in;
      p12_sync <= p12_meta;
    end
  end

  always_comb begin
    port12_input = 8'h00;
    port12_input[P12_PIN1_BIT] = p12_sync[0];
    port12_input[P12_PIN2_BIT] = p12_sync[1];
    port12_input[INPUT_ONLY_BIT] = reset_pin_select_bit & input_only_port_bit;
  end

  always_comb begin
    unique case (sel)
      SEL_NONE: next_rdata = 8'h00;
      SEL_P0: next_rdata = port_read(port0_data, port0_direction,
                                     {6'h00, p0_if.sync}, P0_MASK);
      SEL_P2: next_rdata = port_read(port2_data, port2_direction,
                                     {2'h0, p2_if.sync}, P2_MASK);
      SEL_P3: next_rdata = port_read(port3_data, port3_direction,
                                     {5'h00, p3_if.sync}, P3_MASK);
      SEL_P6: next_rdata = port_read(port6_data, port6_direction,
                                     {4'h0, p6_if.sync}, P6_MASK);
      SEL_P12: next_rdata = port12_input;
      SEL_DIR0: next_rdata = port0_direction;
      SEL_DIR2: next_rdata = port2_direction;
      SEL_DIR3: next_rdata = port3_direction;
      SEL_MODE6: next_rdata = port6_output_driver_mode;
      SEL_RSTSEL: next_rdata = reset_pin_function_select;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  a_mode_byte_write: assert property (@(posedge i_mclk) disable iff (i_rst)
    (sel == SEL_MODE6 && i_wr) |=> port6_output_driver_mode == ($past(i_wdata) & MODE6_MASK))
    else $error("Mode byte write not stored.");

  a_rstsel_bit_write: assert property (@(posedge i_mclk) disable iff (i_rst)
    (sel == SEL_RSTSEL && i_wr_bit && !i_wr && i_bit_pos == 3'h0)
    |=> reset_pin_select_bit == $past(i_wdata[0]))
    else $error("Reset select bit write not stored.");

  a_reset_clears_modes: assert property (@(posedge i_mclk)
    i_rst |=> (port6_output_driver_mode == 8'h00 && reset_pin_function_select == 8'h00))
    else $error("Mode registers not cleared by reset.");

  a_cmos_drive: assert property (@(posedge i_mclk) disable iff (i_rst)
    !port6_output_driver_mode[1] |=> o_p6_oe[1] && o_p6_out[1] == $past(port6_data[1]))
    else $error("Push-pull pin not driving its data.");

  a_od_sinks_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
    (port6_output_driver_mode[0] && !port6_data[0]) |=> (o_p6_oe[0] && !o_p6_out[0]))
    else $error("Open-drain pin not sinking a zero.");

  a_od_releases_one: assert property (@(posedge i_mclk) disable iff (i_rst)
    (port6_output_driver_mode[0] && port6_data[0]) |=> !o_p6_oe[0])
    else $error("Open-drain pin driving a one.");

  a_ext_reset_req: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!reset_pin_select_bit && !input_only_port_bit) |=> o_ext_reset_req)
    else $error("Low reset pin gave no reset request.");

  a_port_mode_no_rst: assert property (@(posedge i_mclk) disable iff (i_rst)
    reset_pin_select_bit [*2] |=> !o_ext_reset_req)
    else $error("Port-mode pin raised a reset request.");

  a_port_mode_read: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_rd && sel == SEL_P12 && reset_pin_select_bit)
    |=> o_rdata[INPUT_ONLY_BIT] == $past(input_only_port_bit))
    else $error("Input-only pin level not read back.");

  c_od_pull_low: cover property (@(posedge i_mclk) disable iff (i_rst)
    port6_output_driver_mode[0] ##1 (o_p6_oe[0] && !o_p6_out[0]));

  c_ext_reset: cover property (@(posedge i_mclk) disable iff (i_rst)
    o_ext_reset_req);

  c_port_mode_low: cover property (@(posedge i_mclk) disable iff (i_rst)
    reset_pin_select_bit && !input_only_port_bit ##1 !o_ext_reset_req);

endmodule

// ==== pomrps_pkg.sv ====
package pomrps_pkg;

  localparam logic [15:0] ADDR_P0_DATA = 16'hff00;
  localparam logic [15:0] ADDR_P2_DATA = 16'hff02;
  localparam logic [15:0] ADDR_P3_DATA = 16'hff03;
  localparam logic [15:0] ADDR_P6_DATA = 16'hff06;
  localparam logic [15:0] ADDR_P12_INPUT = 16'hff0c;
  localparam logic [15:0] ADDR_P0_DIR = 16'hff20;
  localparam logic [15:0] ADDR_P2_DIR = 16'hff22;
  localparam logic [15:0] ADDR_P3_DIR = 16'hff23;
  localparam logic [15:0] ADDR_P6_MODE = 16'hff2a;
  localparam logic [15:0] ADDR_RST_SEL = 16'hff2b;

  localparam int P0_PINS = 2;
  localparam int P2_PINS = 6;
  localparam int P3_PINS = 3;
  localparam int P6_PINS = 4;

  localparam logic [7:0] P0_MASK = 8'h03;
  localparam logic [7:0] P2_MASK = 8'h3f;
  localparam logic [7:0] P3_MASK = 8'h07;
  localparam logic [7:0] P6_MASK = 8'h0f;
  localparam logic [7:0] MODE6_MASK = 8'h0f;
  localparam logic [7:0] RST_SEL_MASK = 8'h01;

  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] MODE6_RST = 8'h00;
  localparam logic [7:0] RST_SEL_RST = 8'h00;
  localparam logic [7:0] FILL_ZERO = 8'h00;
  localparam logic [7:0] FILL_ONE = 8'hff;

  localparam int RST_SEL_BIT = 0;
  localparam int INPUT_ONLY_BIT = 5;
  localparam int P12_PIN1_BIT = 1;
  localparam int P12_PIN2_BIT = 2;
  localparam logic SYNC_IDLE = 1'b1;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_P0, SEL_P2, SEL_P3, SEL_P6, SEL_P12,
    SEL_DIR0, SEL_DIR2, SEL_DIR3, SEL_MODE6, SEL_RSTSEL
  } pomrps_sel_t;

endpackage

// ==== pomrps_pin_if.sv ====
`timescale 1ns/10ps
interface pomrps_pin_if #(parameter int N = 8);
  logic [N-1:0] value;
  logic [N-1:0] dir_in;
  logic [N-1:0] open_drain;
  logic [N-1:0] pad_out;
  logic [N-1:0] pad_oe;
  logic [N-1:0] sync;
  modport core (output value, dir_in, open_drain, input pad_out, pad_oe, sync);
  modport drv (input value, dir_in, open_drain, output pad_out, pad_oe, sync);
endinterface

// ==== pomrps_pin_drv.sv ====
`timescale 1ns/10ps
module pomrps_pin_drv
  import pomrps_pkg::*;
#(
  parameter int N = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [N-1:0] i_pad_in,
  pomrps_pin_if.drv pins
);

  if (N < 1 || N > 8) begin : g_bad_width
    $error("pomrps_pin_drv: N must be 1 to 8.");
  end

  logic [N-1:0] meta;

  for (genvar b = 0; b < N; b++) begin : g_bit
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        pins.pad_out[b] <= 1'b0;
        pins.pad_oe[b] <= 1'b0;
      end else if (pins.open_drain[b]) begin
        // Open drain only ever sinks; a one releases the pin.
        pins.pad_out[b] <= 1'b0;
        pins.pad_oe[b] <= ~pins.dir_in[b] & ~pins.value[b];
      end else begin
        pins.pad_out[b] <= pins.value[b];
        pins.pad_oe[b] <= ~pins.dir_in[b];
      end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        meta[b] <= SYNC_IDLE;
        pins.sync[b] <= SYNC_IDLE;
      end else begin
        meta[b] <= i_pad_in[b];
        pins.sync[b] <= meta[b];
      end
    end
  end

endmodule

// ==== pomrps_rst_sel.sv ====
`timescale 1ns/10ps
module pomrps_rst_sel
  import pomrps_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_pin_n,
  input wire logic i_port_mode,
  output logic o_level,
  output logic o_reset_req
);

  logic meta;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      meta <= SYNC_IDLE;
      o_level <= SYNC_IDLE;
    end else begin
      meta <= i_pin_n;
      o_level <= meta;
    end
  end

  // In port mode a low pin is only data and never asks for a reset.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_reset_req <= 1'b0;
    end else begin
      o_reset_req <= ~i_port_mode & ~o_level;
    end
  end

endmodule

// ==== pomrps_pad_model.sv ====
`timescale 1ns/10ps
module pomrps_pad_model #(
  parameter int N = 4
) (
  input wire logic [N-1:0] i_out,
  input wire logic [N-1:0] i_oe,
  input wire logic [N-1:0] i_ext_low,
  output logic [N-1:0] o_level
);
  // A released line is pulled high unless a far device sinks it.
  assign o_level = (i_oe & i_out) | (~i_oe & ~i_ext_low);
endmodule

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top
  import pomrps_pkg::*;
;
  logic mclk, rst, wr, wr_bit, rd, rst_pin_n, ext_req;
  logic [15:0] addr;
  logic [2:0] bit_pos;
  logic [7:0] wdata, rdata;
  logic [1:0] p0_out, p0_oe, p0_pad, p12_in;
  logic [5:0] p2_out, p2_oe, p2_pad;
  logic [2:0] p3_out, p3_oe, p3_pad;
  logic [3:0] p6_out, p6_oe, p6_ext_low, p6_lvl;
  logic [1:0] p0_lvl;
  logic [5:0] p2_lvl;
  logic [2:0] p3_lvl;
  logic [15:0] ra [11];
  logic [7:0] rv [11];
  logic [7:0] acc;
  int miscompares, checks, cycles;

  assign p0_lvl = (p0_oe & p0_out) | (~p0_oe & p0_pad);
  assign p2_lvl = (p2_oe & p2_out) | (~p2_oe & p2_pad);
  assign p3_lvl = (p3_oe & p3_out) | (~p3_oe & p3_pad);

  pomrps_top i_pomrps_top (
    .i_mclk(mclk), .i_rst(rst), .i_addr(addr), .i_wr(wr), .i_wr_bit(wr_bit),
    .i_bit_pos(bit_pos), .i_wdata(wdata), .i_rd(rd), .o_rdata(rdata),
    .i_p0_in(p0_lvl), .o_p0_out(p0_out), .o_p0_oe(p0_oe),
    .i_p2_in(p2_lvl), .o_p2_out(p2_out), .o_p2_oe(p2_oe),
    .i_p3_in(p3_lvl), .o_p3_out(p3_out), .o_p3_oe(p3_oe),
    .i_p6_in(p6_lvl), .o_p6_out(p6_out), .o_p6_oe(p6_oe),
    .i_p12_in(p12_in), .i_rst_pin_n(rst_pin_n), .o_ext_reset_req(ext_req)
  );

  pomrps_pad_model #(.N(P6_PINS)) i_pomrps_pad_model (
    .i_out(p6_out), .i_oe(p6_oe), .i_ext_low(p6_ext_low), .o_level(p6_lvl)
  );

  always #2 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
    settle(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    settle(1);
    wr = 1'b0;
  endtask

  task automatic wr_one(input logic [15:0] a, input logic [2:0] pos, input logic b);
    settle(1);
    addr = a;
    bit_pos = pos;
    wdata = {7'h00, b};
    wr_bit = 1'b1;
    settle(1);
    wr_bit = 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    settle(1);
    addr = a;
    rd = 1'b1;
    settle(1);
    rd = 1'b0;
    cmp8($sformatf("reg %h", a), exp, rdata);
  endtask

  ////////////////////////////////////////////////////////////////////////////////

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    wr = 1'b0;
    wr_bit = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    bit_pos = 3'h0;
    wdata = 8'h00;
    rst_pin_n = 1'b1;
    p0_pad = 2'h2;
    p2_pad = 6'h2a;
    p3_pad = 3'h5;
    p6_ext_low = 4'h0;
    p12_in = 2'h1;
    miscompares = 0;
    checks = 0;
    cycles = 0;
    ra = '{ADDR_P0_DATA, ADDR_P2_DATA, ADDR_P3_DATA, ADDR_P6_DATA, ADDR_P12_INPUT,
           ADDR_P0_DIR, ADDR_P2_DIR, ADDR_P3_DIR, ADDR_P6_MODE, ADDR_RST_SEL, 16'hff01};
    rv = '{8'h02, 8'h2a, 8'h05, 8'h00, 8'h02, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
    settle(6);
    rst = 1'b0;
    // Port and reset-pin synchronisers leave reset idle high, the port 12 ones low; all need two edges for the real level.
    settle(2);
    // Reset values; input pins read their pad level.
    for (int i = 0; i < 11; i++) begin
      rd_chk(ra[i], rv[i]);
    end
    // Read-only and unmapped places ignore writes.
    wr_byte(ADDR_P12_INPUT, 8'hff);
    wr_byte(16'hff01, 8'hff);
    rd_chk(ADDR_P12_INPUT, 8'h02);
    rd_chk(16'hff01, 8'h00);
    // Port 0 pin 0 as output, pin 1 stays input.
    wr_byte(ADDR_P0_DIR, 8'hfe);
    wr_byte(ADDR_P0_DATA, 8'h03);
    settle(1);
    cmp8("p0_oe", 8'h01, {6'h00, p0_oe});
    cmp8("p0_out", 8'h01, {6'h00, p0_out & p0_oe});
    rd_chk(ADDR_P0_DIR, 8'hfe);
    rd_chk(ADDR_P0_DATA, 8'h03);
    // Ports 2 and 3 mix outputs and inputs; outputs read the latch.
    wr_byte(ADDR_P2_DIR, 8'hc3);
    wr_byte(ADDR_P2_DATA, 8'h15);
    wr_byte(ADDR_P3_DIR, 8'hfa);
    wr_byte(ADDR_P3_DATA, 8'h01);
    settle(1);
    cmp8("p2_oe", 8'h3c, {2'h0, p2_oe});
    cmp8("p2_out", 8'h14, {2'h0, p2_out & p2_oe});
    cmp8("p3_oe", 8'h05, {5'h00, p3_oe});
    cmp8("p3_out", 8'h01, {5'h00, p3_out & p3_oe});
    rd_chk(ADDR_P2_DATA, 8'h16);
    rd_chk(ADDR_P3_DATA, 8'h01);
    // Mode register keeps four bits; pins 0,1 open drain for the two-wire bus.
    wr_byte(ADDR_P6_DATA, 8'h00);
    wr_byte(ADDR_P6_MODE, 8'hff);
    rd_chk(ADDR_P6_MODE, 8'h0f);
    wr_byte(ADDR_P6_MODE, 8'h03);
    settle(1);
    cmp8("p6_oe", 8'h0f, {4'h0, p6_oe});
    cmp8("p6_out", 8'h00, {4'h0, p6_out & p6_oe});
    wr_byte(ADDR_P6_DATA, 8'h0f);
    settle(1);
    cmp8("p6_oe", 8'h0c, {4'h0, p6_oe});
    cmp8("p6_out", 8'h0c, {4'h0, p6_out & p6_oe});
    cmp8("p6_lvl", 8'h0f, {4'h0, p6_lvl});
    // Pin 0 back to push-pull for the serial transmit line.
    wr_one(ADDR_P6_MODE, 3'h0, 1'b0);
    settle(1);
    rd_chk(ADDR_P6_MODE, 8'h02);
    cmp8("p6_oe", 8'h0d, {4'h0, p6_oe});
    cmp8("p6_out", 8'h0d, {4'h0, p6_out & p6_oe});
    // Each mode bit is set on its own.
    wr_byte(ADDR_P6_MODE, 8'h00);
    acc = 8'h00;
    for (int i = 0; i < 4; i++) begin
      acc[i] = 1'b1;
      wr_one(ADDR_P6_MODE, 3'(i), 1'b1);
      rd_chk(ADDR_P6_MODE, acc);
    end
    wr_one(ADDR_P6_MODE, 3'h3, 1'b0);
    wr_one(ADDR_P6_MODE, 3'h5, 1'b1);
    rd_chk(ADDR_P6_MODE, 8'h07);
    // Shared pin in reset mode raises a request.
    rst_pin_n = 1'b0;
    settle(4);
    cmp8("ext_req", 8'h01, {7'h00, ext_req});
    rd_chk(ADDR_P12_INPUT, 8'h02);
    rst_pin_n = 1'b1;
    settle(4);
    cmp8("ext_req", 8'h00, {7'h00, ext_req});
    // Shared pin as input-only port bit.
    wr_byte(ADDR_RST_SEL, 8'hfe);
    rd_chk(ADDR_RST_SEL, 8'h00);
    wr_one(ADDR_RST_SEL, 3'h0, 1'b1);
    rd_chk(ADDR_RST_SEL, 8'h01);
    rst_pin_n = 1'b0;
    settle(4);
    cmp8("ext_req", 8'h00, {7'h00, ext_req});
    rd_chk(ADDR_P12_INPUT, 8'h02);
    rst_pin_n = 1'b1;
    p12_in = 2'h3;
    settle(4);
    rd_chk(ADDR_P12_INPUT, 8'h26);
    // A second reset in mid-run clears both mode registers.
    rst = 1'b1;
    settle(2);
    rst = 1'b0;
    rd_chk(ADDR_P6_MODE, 8'h00);
    rd_chk(ADDR_RST_SEL, 8'h00);
    final_report();
  end
endmodule
